/* hw/nvm_port_defs.vh */
// constants for the test-port programming logic
`ifndef NVM_PORT_DEFS_VH
`define NVM_PORT_DEFS_VH
`define IR_W           4
`define IR_CAPTURE     4'h1
`define IR_RESET       4'hc
`define IR_UNLOCK      4'h4
`define IR_COMMAND     4'h5
`define IR_PAGEREAD    4'h7
`define IR_BYPASS      4'hf
`define UNLOCK_SIG     16'ha370
`define CMD_W          15
`define OPC_ENTER      7'h23
`define OPC_ADDR_HI    7'h07
`define OPC_ADDR_LO    7'h03
`define OPC_DATA_LO    7'h13
`define OPC_DATA_HI    7'h17
`define OPC_LATCH      7'h77
`define OPC_IDLE_HI    7'h37
`define OPC_IDLE_LO    7'h33
`define OPC_STROBE_HI  7'h35
`define OPC_STROBE_LO  7'h31
`define OPC_READ_A     7'h32
`define OPC_READ_B     7'h36
`define SEL_ERASE      8'h80
`define SEL_FWRITE     8'h10
`define SEL_FREAD      8'h02
`define SEL_EWRITE     8'h11
`define SEL_EREAD      8'h03
`define SEL_FUSE       8'h40
`define SEL_LOCK       8'h20
`define DONE_BIT       9
`define OP_W           3
`define OP_ERASE       3'h0
`define OP_LATCH       3'h1
`define OP_WFLASH      3'h2
`define OP_WEEPROM     3'h3
`define OP_WFUSE_HI    3'h4
`define OP_WFUSE_LO    3'h5
`define OP_WLOCK       3'h6
`endif

/* hw/nvm_port.v */
// test-port programming logic for on-chip flash, eeprom and fuses, with its command fifo
`timescale 1ns/100ps
`default_nettype none
`include "nvm_port_defs.vh"

// ********************
// command fifo
// ********************
module cmd_fifo #(
  parameter WIDTH = 35,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;
  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // cmd_fifo

// ********************
// programming port
// ********************
module nvm_port #(
  parameter TIMEOUT_SHORT = 16,
  parameter TIMEOUT_LONG  = 4096,
  parameter FIFO_DEPTH    = 32
) (
  input  wire        MCLK,
  input  wire        RST,
  input  wire        TCK,
  input  wire        TMS,
  input  wire        TDI,
  output reg         TDO,
  output reg         TDO_OE,
  input  wire        TIMEOUT_SEL,
  output wire        CORE_RESET,
  output wire        PROG_ENABLED,
  output reg  [15:0] NVM_RADDR,
  output reg         NVM_RSPACE,
  input  wire [15:0] NVM_RDATA,
  output wire [2:0]  NVM_OP,
  output wire [15:0] NVM_ADDR,
  output wire [15:0] NVM_WDATA,
  output wire        NVM_VALID,
  input  wire        NVM_READY,
  input  wire        NVM_BUSY
);
  localparam S_TLR   = 16'h0001;
  localparam S_RTI   = 16'h0002;
  localparam S_SELDR = 16'h0004;
  localparam S_CAPDR = 16'h0008;
  localparam S_SHDR  = 16'h0010;
  localparam S_EX1DR = 16'h0020;
  localparam S_PADR  = 16'h0040;
  localparam S_EX2DR = 16'h0080;
  localparam S_UPDR  = 16'h0100;
  localparam S_SELIR = 16'h0200;
  localparam S_CAPIR = 16'h0400;
  localparam S_SHIR  = 16'h0800;
  localparam S_EX1IR = 16'h1000;
  localparam S_PAIR  = 16'h2000;
  localparam S_EX2IR = 16'h4000;
  localparam S_UPIR  = 16'h8000;
  localparam FW      = `OP_W + 32;

  reg  [2:0]        tck_sync;
  reg  [1:0]        tms_sync;
  reg  [1:0]        tdi_sync;
  wire              tck_rise;
  wire              tck_fall;
  wire              tms;
  wire              tdi;
  reg  [15:0]       state;
  reg  [15:0]       next_state;
  reg  [`IR_W-1:0]  ir_shift;
  reg  [`IR_W-1:0]  ir;
  reg               reset_bit;
  reg  [15:0]       unlock_shift;
  reg  [15:0]       unlock;
  reg  [`CMD_W-1:0] cmd;
  reg  [`CMD_W-1:0] applied;
  reg               pending;
  reg               bypass;
  reg  [7:0]        op_class;
  reg  [15:0]       data_word;
  reg  [7:0]        result;
  reg               high_next;
  reg  [15:0]       timeout;
  reg               push;
  reg  [`OP_W-1:0]  push_op;
  wire              fifo_ready;
  wire              done;
  wire [6:0]        opc;
  wire [7:0]        arg;
  wire [FW-1:0]     fifo_out;

  // ********************
  // pin sampling
  // ********************
  always @(posedge MCLK) begin
    if (RST) begin
      tck_sync <= 3'h0;
      tms_sync <= 2'h3;
      tdi_sync <= 2'h0;
    end else begin
      tck_sync <= {tck_sync[1:0], TCK};
      tms_sync <= {tms_sync[0], TMS};
      tdi_sync <= {tdi_sync[0], TDI};
    end
  end
  assign tck_rise = tck_sync[1] & ~tck_sync[2];
  assign tck_fall = ~tck_sync[1] & tck_sync[2];
  assign tms      = tms_sync[1];
  assign tdi      = tdi_sync[1];

  // ********************
  // test port state machine
  // ********************
  always @* begin
    next_state = S_TLR;
    case (state)
      S_TLR:   next_state = tms ? S_TLR : S_RTI;
      S_RTI:   next_state = tms ? S_SELDR : S_RTI;
      S_SELDR: next_state = tms ? S_SELIR : S_CAPDR;
      S_CAPDR: next_state = tms ? S_EX1DR : S_SHDR;
      S_SHDR:  next_state = tms ? S_EX1DR : S_SHDR;
      S_EX1DR: next_state = tms ? S_UPDR : S_PADR;
      S_PADR:  next_state = tms ? S_EX2DR : S_PADR;
      S_EX2DR: next_state = tms ? S_UPDR : S_SHDR;
      S_UPDR:  next_state = tms ? S_SELDR : S_RTI;
      S_SELIR: next_state = tms ? S_TLR : S_CAPIR;
      S_CAPIR: next_state = tms ? S_EX1IR : S_SHIR;
      S_SHIR:  next_state = tms ? S_EX1IR : S_SHIR;
      S_EX1IR: next_state = tms ? S_UPIR : S_PAIR;
      S_PAIR:  next_state = tms ? S_EX2IR : S_PAIR;
      S_EX2IR: next_state = tms ? S_UPIR : S_SHIR;
      S_UPIR:  next_state = tms ? S_SELDR : S_RTI;
      default: next_state = S_TLR;
    endcase
  end

  assign opc          = applied[14:8];
  assign arg          = applied[7:0];
  assign PROG_ENABLED = (unlock == `UNLOCK_SIG);
  // completion only once queued work has drained
  assign done         = ~NVM_VALID & ~NVM_BUSY;

  // ********************
  // data registers
  // ********************
  always @(posedge MCLK) begin
    if (RST) begin
      state        <= S_TLR;
      ir_shift     <= {`IR_W{1'b0}};
      ir           <= `IR_BYPASS;
      reset_bit    <= 1'b0;
      unlock_shift <= 16'h0000;
      unlock       <= 16'h0000;
      cmd          <= {`CMD_W{1'b0}};
      applied      <= {`CMD_W{1'b0}};
      pending      <= 1'b0;
      bypass       <= 1'b0;
      high_next    <= 1'b0;
    end else if (tck_rise) begin
      state <= next_state;
      case (state)
        S_TLR: begin
          ir <= `IR_BYPASS;
        end
        S_CAPIR: begin
          ir_shift <= `IR_CAPTURE;
        end
        // lsb first on every chain
        S_SHIR: begin
          ir_shift <= {tdi, ir_shift[`IR_W-1:1]};
        end
        S_UPIR: begin
          ir        <= ir_shift;
          // byte order restarts with each new instruction
          high_next <= 1'b0;
        end
        S_CAPDR: begin
          if (ir == `IR_COMMAND) begin
            cmd <= {5'h00, done, 1'b0, result};
          end else if (ir == `IR_PAGEREAD) begin
            cmd[7:0]  <= high_next ? NVM_RDATA[15:8] : NVM_RDATA[7:0];
            high_next <= ~high_next;
          end
        end
        S_SHDR: begin
          if (ir == `IR_RESET) begin
            reset_bit <= tdi;
          end else if (ir == `IR_UNLOCK) begin
            unlock_shift <= {tdi, unlock_shift[15:1]};
          end else if (ir == `IR_COMMAND) begin
            cmd <= {tdi, cmd[`CMD_W-1:1]};
          end else if (ir == `IR_PAGEREAD) begin
            cmd[7:0] <= {tdi, cmd[7:1]};
          end else begin
            bypass <= tdi;
          end
        end
        S_UPDR: begin
          if (ir == `IR_UNLOCK) begin
            unlock <= unlock_shift;
          end else if (ir == `IR_COMMAND) begin
            applied <= cmd;
            pending <= 1'b1;
          end
        end
        S_RTI: begin
          // one idle cycle executes; a full fifo holds it off
          if (pending & (fifo_ready | ~push)) begin
            pending <= 1'b0;
          end
        end
        default: begin
          bypass <= bypass;
        end
      endcase
    end
  end

  // ********************
  // test data out
  // ********************
  always @(posedge MCLK) begin
    if (RST) begin
      TDO    <= 1'b0;
      TDO_OE <= 1'b0;
    end else if (tck_fall) begin
      TDO_OE <= (state == S_SHDR) | (state == S_SHIR);
      if (state == S_SHIR) begin
        TDO <= ir_shift[0];
      end else if (ir == `IR_RESET) begin
        TDO <= reset_bit;
      end else if (ir == `IR_UNLOCK) begin
        TDO <= unlock_shift[0];
      end else if ((ir == `IR_COMMAND) | (ir == `IR_PAGEREAD)) begin
        TDO <= cmd[0];
      end else begin
        TDO <= bypass;
      end
    end
  end

  // ********************
  // command decode
  // ********************
  always @* begin
    push    = 1'b0;
    push_op = `OP_ERASE;
    if (opc == `OPC_LATCH) begin
      push    = (op_class == `SEL_FWRITE) | (op_class == `SEL_EWRITE);
      push_op = `OP_LATCH;
    end else if (opc == `OPC_STROBE_HI) begin
      push    = (op_class == `SEL_FWRITE) | (op_class == `SEL_FUSE);
      push_op = (op_class == `SEL_FUSE) ? `OP_WFUSE_HI : `OP_WFLASH;
    end else if (opc == `OPC_STROBE_LO) begin
      push = 1'b1;
      if (op_class == `SEL_ERASE) begin
        push_op = `OP_ERASE;
      end else if (op_class == `SEL_EWRITE) begin
        push_op = `OP_WEEPROM;
      end else if (op_class == `SEL_FUSE) begin
        push_op = `OP_WFUSE_LO;
      end else if (op_class == `SEL_LOCK) begin
        push_op = `OP_WLOCK;
      end else begin
        push = 1'b0;
      end
    end
  end

  always @(posedge MCLK) begin
    if (RST) begin
      op_class   <= 8'h00;
      data_word  <= 16'h0000;
      result     <= 8'h00;
      NVM_RADDR  <= 16'h0000;
      NVM_RSPACE <= 1'b0;
    end else if (tck_rise) begin
      if ((state == S_CAPDR) & (ir == `IR_PAGEREAD) & high_next) begin
        NVM_RADDR <= NVM_RADDR + 16'h0001;
      end
      if ((state == S_RTI) & pending & PROG_ENABLED & (fifo_ready | ~push)) begin
        case (opc)
          `OPC_ENTER: begin
            op_class   <= arg;
            NVM_RSPACE <= (arg == `SEL_EREAD);
          end
          `OPC_ADDR_HI: begin
            NVM_RADDR[15:8] <= arg;
          end
          `OPC_ADDR_LO: begin
            NVM_RADDR[7:0] <= arg;
          end
          `OPC_DATA_LO: begin
            data_word[7:0] <= arg;
          end
          `OPC_DATA_HI: begin
            data_word[15:8] <= arg;
          end
          `OPC_READ_B: begin
            result <= NVM_RDATA[7:0];
          end
          `OPC_IDLE_HI: begin
            if (op_class == `SEL_FREAD) begin
              result <= NVM_RDATA[15:8];
            end
          end
          `OPC_IDLE_LO: begin
            if (op_class == `SEL_EREAD) begin
              result <= NVM_RDATA[7:0];
            end
          end
          default: begin
            result <= result;
          end
        endcase
      end
    end
  end

  // ********************
  // core reset
  // ********************
  always @(posedge MCLK) begin
    if (RST) begin
      timeout <= 16'h0000;
    end else if (reset_bit) begin
      timeout <= TIMEOUT_SEL ? TIMEOUT_LONG[15:0] : TIMEOUT_SHORT[15:0];
    end else if (timeout != 16'h0000) begin
      timeout <= timeout - 16'h0001;
    end
  end
  assign CORE_RESET = reset_bit | (timeout != 16'h0000);

  // ********************
  // memory command queue
  // ********************
  cmd_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH),
    .AW    (5)
  ) queue (
    .clk       (MCLK),
    .rst       (RST),
    .in_data   ({push_op, NVM_RADDR, data_word}),
    .in_valid  (tck_rise & (state == S_RTI) & pending & PROG_ENABLED & push),
    .in_ready  (fifo_ready),
    .out_data  (fifo_out),
    .out_valid (NVM_VALID),
    .out_ready (NVM_READY)
  );
  assign NVM_OP    = fifo_out[FW-1:32];
  assign NVM_ADDR  = fifo_out[31:16];
  assign NVM_WDATA = fifo_out[15:0];
endmodule // nvm_port
`default_nettype wire

/* test/nvm_port_props.sv */
// assertion checker for the test-port programming logic
`timescale 1ns/100ps
`default_nettype none
// ****************
// port checker
// ****************
module nvm_port_chk #(
  parameter TIMEOUT_SHORT = 16
) (
  input wire logic        MCLK,
  input wire logic        RST,
  input wire logic        TCK,
  input wire logic        TDO,
  input wire logic        TDO_OE,
  input wire logic        CORE_RESET,
  input wire logic        PROG_ENABLED,
  input wire logic [15:0] NVM_RADDR,
  input wire logic [2:0]  NVM_OP,
  input wire logic [15:0] NVM_ADDR,
  input wire logic [15:0] NVM_WDATA,
  input wire logic        NVM_VALID,
  input wire logic        NVM_READY
);
  // saturating count of core reset cycles
  logic [15:0] hi_cnt;
  always @(posedge MCLK) begin
    if (RST || !CORE_RESET)
      hi_cnt <= 16'h0000;
    else if (hi_cnt != 16'hffff)
      hi_cnt <= hi_cnt + 16'h0001;
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  AST_RST_CLEARS: assert property (disable iff (1'b0) RST |=> !PROG_ENABLED && !NVM_VALID)
    else $error("outputs not cleared by reset");
  AST_HEAD_STANDS: assert property (NVM_VALID && !NVM_READY |=> NVM_VALID
    && $stable(NVM_OP) && $stable(NVM_ADDR) && $stable(NVM_WDATA))
    else $error("queue head changed while stalled");
  AST_LOCKED_NO_QUEUE: assert property ($rose(NVM_VALID) |-> PROG_ENABLED)
    else $error("operation queued while locked");
  AST_RESET_TIMEOUT: assert property ($fell(CORE_RESET) |-> hi_cnt >= TIMEOUT_SHORT)
    else $error("core reset released too early");
  AST_UNLOCK_HOLDS: assert property ($rose(PROG_ENABLED) |=> PROG_ENABLED [*8])
    else $error("programming enable dropped at once");
  AST_OE_AT_LOW: assert property ($changed(TDO_OE) |-> !TCK)
    else $error("output enable moved while test clock high");
  AST_TDO_AT_LOW: assert property ($changed(TDO) |-> !TCK)
    else $error("data out moved while test clock high");
  AST_PC_AT_HIGH: assert property ($changed(NVM_RADDR) |-> TCK)
    else $error("address moved while test clock low");
endmodule // nvm_port_chk
bind nvm_port nvm_port_chk #(.TIMEOUT_SHORT(TIMEOUT_SHORT)) chk (
  .MCLK(MCLK), .RST(RST), .TCK(TCK), .TDO(TDO), .TDO_OE(TDO_OE),
  .CORE_RESET(CORE_RESET), .PROG_ENABLED(PROG_ENABLED), .NVM_RADDR(NVM_RADDR),
  .NVM_OP(NVM_OP), .NVM_ADDR(NVM_ADDR), .NVM_WDATA(NVM_WDATA),
  .NVM_VALID(NVM_VALID), .NVM_READY(NVM_READY)
);
`default_nettype wire

/* test/nvm_prog_model.sv */
// behavioural test-port programmer
`timescale 1ns/100ps
`default_nettype none
// ****************
// programmer model
// ****************
module nvm_prog_model (
  input  wire logic mclk,
  input  wire logic tdo,
  input  wire logic tdo_oe,
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // clock stands low between ticks; data turns to its inverse once taken
  // an undriven data out reads as the inverse of its last value
  task automatic tick(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    repeat (4) @(negedge mclk);
    tck = 1'b1;
    q = tdo_oe ? tdo : ~tdo;
    repeat (2) @(negedge mclk);
    tdi = ~d;
    repeat (2) @(negedge mclk);
    tck = 1'b0;
  endtask
  // from idle through capture, shift and update, then one executing idle tick
  task automatic scan(input logic ir, input int n, input logic [15:0] din,
                      output logic [15:0] dout);
    logic q;
    dout = 16'h0000;
    tick(1'b1, 1'b0, q);
    if (ir)
      tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
    tick(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], q);
      dout[i] = q;
    end
    tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
    tick(1'b0, 1'b0, q);
  endtask
endmodule // nvm_prog_model
`default_nettype wire

/* test/nvm_port_tb_top.sv */
// self-checking bench for the test-port programming logic
`timescale 1ns/100ps
`default_nettype none
`include "nvm_port_defs.vh"
module nvm_port_tb_top;
  logic        mclk, rst, ready, busy, tsel;
  wire         tck, tms, tdi, tdo, tdo_oe, core_reset, prog_en, rspace, valid;
  wire  [15:0] raddr, rdata, addr, wdata;
  wire  [2:0]  op;
  logic [3:0]  cur;
  int          n_errors, comparisons;
  // row: ir (0 keeps), check kind, shifted value, expected
  logic [39:0] rows [$] = '{40'hc4_0001_0001, 40'h43_a371_0000, 40'h43_a370_0001,
    40'h50_2302_0000, 40'h00_0712_0000, 40'h00_0334_0000, 40'h00_3200_0000,
    40'h00_3600_0000, 40'h01_3700_026e, 40'h01_2303_02d1, 40'h00_0356_0000,
    40'h00_3300_0000, 40'h01_3300_02f3, 40'h00_2310_0000, 40'h00_0700_0000,
    40'h00_0310_0000, 40'h00_13aa_0000, 40'h00_17bb_0000, 40'h00_3700_0000,
    40'h00_7700_0000, 40'h00_3700_0000, 40'h00_3700_0000, 40'h00_3500_0000,
    40'h00_3700_0000, 40'h05_3700_0000, 40'h00_2311_0000, 40'h00_13cc_0000,
    40'h00_3700_0000, 40'h00_7700_0000, 40'h00_3700_0000, 40'h00_3300_0000,
    40'h00_3100_0000, 40'h00_3300_0000, 40'h00_2340_0000, 40'h00_13dd_0000,
    40'h00_3700_0000, 40'h00_3500_0000, 40'h00_3700_0000, 40'h00_13ee_0000,
    40'h00_3300_0000, 40'h00_3100_0000, 40'h00_3300_0000, 40'h00_2320_0000,
    40'h00_13ff_0000, 40'h00_3300_0000, 40'h00_3100_0000, 40'h00_3300_0000,
    40'h00_2380_0000, 40'h00_3180_0000, 40'h00_3380_0000, 40'h00_2302_0000,
    40'h00_0700_0000, 40'h00_03fe_0000, 40'h71_0000_00a4, 40'h01_0000_00c3,
    40'h01_0000_00a5, 40'h01_0000_00c3};
  logic [2:0]  ops [8] = '{`OP_LATCH, `OP_WFLASH, `OP_LATCH, `OP_WEEPROM,
                           `OP_WFUSE_HI, `OP_WFUSE_LO, `OP_WLOCK, `OP_ERASE};
  // memory answers at once; eeprom space returns one byte
  assign rdata = rspace ? {8'h00, raddr[7:0] ^ 8'ha5} : raddr ^ 16'hc35a;
  nvm_port #(.TIMEOUT_SHORT(64), .TIMEOUT_LONG(128), .FIFO_DEPTH(32)) dut (
    .MCLK(mclk), .RST(rst), .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe),
    .TIMEOUT_SEL(tsel), .CORE_RESET(core_reset), .PROG_ENABLED(prog_en), .NVM_RADDR(raddr),
    .NVM_RSPACE(rspace), .NVM_RDATA(rdata), .NVM_OP(op), .NVM_ADDR(addr), .NVM_WDATA(wdata),
    .NVM_VALID(valid), .NVM_READY(ready), .NVM_BUSY(busy));
  nvm_prog_model prog (.mclk(mclk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms),
    .tdi(tdi));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic do_row(input logic [39:0] r);
    logic [15:0] d;
    if (r[39:36] != 4'h0) begin
      cur = r[39:36];
      prog.scan(1'b1, `IR_W, {12'h000, cur}, d);
    end
    prog.scan(1'b0, cur == `IR_UNLOCK ? 16 : cur == `IR_COMMAND ? 15 :
              cur == `IR_PAGEREAD ? 8 : 1, r[31:16], d);
    case (r[35:32])
      4'h1: check(d, r[15:0]);
      4'h3: check({15'h0000, prog_en}, r[15:0]);
      4'h4: check({15'h0000, core_reset}, r[15:0]);
      4'h5: check(d & 16'h0200, r[15:0]);
      default: ;
    endcase
  endtask
  initial begin
    logic [15:0] d;
    logic        q;
    rst = 1'b1;
    ready = 1'b0;
    busy = 1'b0;
    tsel = 1'b0;
    n_errors = 0;
    comparisons = 0;
    repeat (8) @(negedge mclk);
    rst = 1'b0;
    check({11'h000, tdo, tdo_oe, core_reset, prog_en, valid}, 16'h0000);
    repeat (3) @(negedge mclk);
    prog.tick(1'b0, 1'b0, q);
    foreach (rows[i]) do_row(rows[i]);
    check(addr, 16'h0010);
    check(wdata, 16'hbbaa);
    foreach (ops[i]) begin
      check({12'h000, valid, op}, {12'h000, 1'b1, ops[i]});
      ready = 1'b1;
      @(negedge mclk);
      ready = 1'b0;
      @(negedge mclk);
    end
    check({15'h0000, valid}, 16'h0000);
    check(raddr, 16'h0100);
    // fill the queue past full while the memory stalls
    do_row(40'h50_2311_0000);
    repeat (32) begin
      do_row(40'h00_3300_0000);
      do_row(40'h00_3100_0000);
      do_row(40'h00_3300_0000);
    end
    do_row(40'h00_3300_0000);
    do_row(40'h00_3100_0000);
    ready = 1'b1;
    d = 16'h0000;
    repeat (40) begin
      if (valid === 1'b1)
        d++;
      @(negedge mclk);
    end
    ready = 1'b0;
    check(d, 16'h0020);
    prog.tick(1'b0, 1'b0, q);
    check({15'h0000, valid}, 16'h0001);
    ready = 1'b1;
    @(negedge mclk);
    ready = 1'b0;
    busy = 1'b1;
    do_row(40'h55_3300_0000);
    busy = 1'b0;
    for (int i = 0; i < 8 && d[9] !== 1'b1; i++) prog.scan(1'b0, 15, 16'h3300, d);
    check(d & 16'h0200, 16'h0200);
    do_row(40'h43_0000_0000);
    do_row(40'h50_2380_0000);
    do_row(40'h00_3180_0000);
    repeat (8) @(negedge mclk);
    check({15'h0000, valid}, 16'h0000);
    do_row(40'hc4_0000_0001);
    for (int i = 0; i < 100 && core_reset !== 1'b0; i++) @(negedge mclk);
    check({15'h0000, core_reset}, 16'h0000);
    // long time-out outlasts the short one
    tsel = 1'b1;
    do_row(40'h04_0001_0001);
    do_row(40'h04_0000_0001);
    repeat (60) @(negedge mclk);
    check({15'h0000, core_reset}, 16'h0001);
    for (int i = 0; i < 100 && core_reset !== 1'b0; i++) @(negedge mclk);
    check({15'h0000, core_reset}, 16'h0000);
    complete_run();
  end
endmodule // nvm_port_tb_top
`default_nettype wire
